// ---- hdl/bus_arbiter_requester.v ----
// Four-level central arbiter, requester and AXI4-Lite control registers
`timescale 1ns/1ps
`include "arb_defs.vh"

// Summary of operation
// RULE1 - Request on exactly one of levels 0..3, chosen by configuration
// RULE2 - Level selection works the same with internal or external arbiter
// RULE3 - Requester sits in the grant chain of its own request level
// RULE4 - Only one central arbiter enabled in the whole system
// RULE5 - Arbiter drives four chain-head grants; disabled arbiter drives none
// RULE6 - External arbiter: other three levels pass grant in to grant out
// RULE7 - Internal arbiter: three heads drive grant out directly
// RULE8 - Internal arbiter enabled: incoming bus grants are ignored
// RULE9 - Arbiter priority: level 3 highest, level 0 lowest
// RULE10 - Reset default: arbiter enabled, request level 0
// RULE11 - Release-on-request: keep bus until another request appears
// RULE12 - Release-on-request: any level's request forces release; code releases only once xfer_req is also low
// RULE13 - Release-when-done: release after each transfer, re-request next
// RULE14 - Acquire and release entirely in hardware
// RULE15 - Release policy selectable, release-on-request default
// RULE16 - Own-level grant enters requester, passed grant goes downstream
// RULE17 - Forward grant when not requesting; keep it when requesting
// RULE18 - Hold request until grant, then take ownership and drop request
// RULE19 - Ownership indicator active while this board owns the bus
module bus_arbiter_requester
(
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address and data
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Local transfer request
    input  wire        xfer_req,
    input  wire        xfer_done,
    output reg         xfer_go,
    // Bus arbitration lines, active high
    input  wire [3:0]  bus_req_in,
    input  wire        bus_busy_in,
    input  wire [3:0]  bus_grant_in,
    output reg  [3:0]  bus_req_out,
    output reg         bus_busy_out,
    output wire [3:0]  bus_grant_out,
    output reg         bus_clear_out,
    // Indicator
    output reg         bus_owner_indicator
);
    localparam ST_IDLE = 2'h0;
    localparam ST_REQ  = 2'h1;
    localparam ST_OWN  = 2'h2;
    localparam ST_REL  = 2'h3;

    reg  [1:0] level_q;
    reg        arb_en_q;
    reg        mode_q;
    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg  [3:0] arb_grant_q;
    reg  [3:0] arb_grant_d;
    reg        req_grant_out_q;
    reg        aw_got_q;
    reg        w_got_q;
    reg  [7:0] aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0] w_strb_q;
    wire       req_grant_in;
    wire [3:0] other_req;

    // Highest pending level, level 3 wins
    function [1:0] top_level;
        input [3:0] r;
        begin
            if (r[3])
                top_level = 2'h3; // RULE9
            else if (r[2])
                top_level = 2'h2;
            else if (r[1])
                top_level = 2'h1;
            else
                top_level = 2'h0;
        end
    endfunction

    // Word decode shared by both paths; byte lanes inside a word alias
    function word_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            word_hit = addr[7:2] == ofs[7:2];
        end
    endfunction

    // Control word as software reads it back
    function [31:0] ctrl_word;
        input [1:0] lvl;
        input       en;
        input       md;
        begin
            ctrl_word                       = 32'h00000000;
            ctrl_word[`CTRL_LEVEL_LSB +: 2] = lvl;
            ctrl_word[`CTRL_ARB_EN_BIT]     = en;
            ctrl_word[`CTRL_MODE_BIT]       = md;
        end
    endfunction

    // Status word: ownership, own request and arbiter grant state
    function [31:0] stat_word;
        input       own;
        input [3:0] req;
        input [3:0] gnt;
        begin
            stat_word                        = 32'h00000000;
            stat_word[`STAT_OWNER_BIT]       = own;
            stat_word[`STAT_REQ_BIT]         = req != 4'h0;
            stat_word[`STAT_ARBBUSY_BIT]     = gnt != 4'h0;
            stat_word[`STAT_ARBLVL_LSB +: 2] = top_level(gnt);
        end
    endfunction

    grant_router u_router
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .arb_en        (arb_en_q),
        .level         (level_q),
        .bus_grant_in  (bus_grant_in),
        .arb_grant     (arb_grant_q),
        .req_grant_out (req_grant_out_q),
        .bus_grant_out (bus_grant_out),
        .req_grant_in  (req_grant_in)
    );

    // Our own request line is on the bus too; mask it for release decisions
    assign other_req = bus_req_in & ~bus_req_out;

    // Central arbiter: grant only while the bus is free and nothing granted
    always @*
    begin
        arb_grant_d = arb_grant_q;
        if (!arb_en_q)
            arb_grant_d = 4'h0; // RULE5
        else if (arb_grant_q != 4'h0)
        begin
            // Hold grant until busy is raised or every request line drops
            if (bus_busy_in || bus_busy_out || bus_req_in == 4'h0)
                arb_grant_d = 4'h0;
        end
        else if (!bus_busy_in && !bus_busy_out && bus_req_in != 4'h0)
            arb_grant_d = 4'h1 << top_level(bus_req_in); // RULE9
    end

    // Requester
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (xfer_req)
                    state_d = ST_REQ;
            ST_REQ:
                if (req_grant_in && !bus_busy_in)
                    state_d = ST_OWN; // RULE18
            ST_OWN:
                if (mode_q == `MODE_RWD && xfer_done)
                    state_d = ST_REL; // RULE13
                else if (mode_q == `MODE_ROR && other_req != 4'h0
                         && !xfer_req)
                    state_d = ST_REL; // RULE11 RULE12
            ST_REL:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q             <= ST_IDLE;
            arb_grant_q         <= 4'h0;
            req_grant_out_q     <= 1'b0;
            bus_req_out         <= 4'h0;
            bus_busy_out        <= 1'b0;
            bus_clear_out       <= 1'b0;
            bus_owner_indicator <= 1'b0;
            xfer_go             <= 1'b0;
        end
        else
        begin
            state_q     <= state_d; // RULE14
            arb_grant_q <= arb_grant_d;
            // Pass grant on only when not wanting the bus
            req_grant_out_q <= req_grant_in && state_q == ST_IDLE
                               && !xfer_req; // RULE17
            bus_req_out <= (state_d == ST_REQ) ?
                           (4'h1 << level_q) : 4'h0; // RULE1 RULE2 RULE3
            bus_busy_out        <= state_d == ST_OWN;
            bus_owner_indicator <= state_d == ST_OWN; // RULE19
            xfer_go             <= state_d == ST_OWN && xfer_req;
            // Ask a release-on-request owner to let go for any pending request
            bus_clear_out <= arb_en_q && bus_busy_in
                             && bus_req_in != 4'h0;
        end
    end

    // AXI4-Lite slave
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            level_q       <= `LEVEL_RST; // RULE10
            arb_en_q      <= `ARB_EN_RST; // RULE10
            mode_q        <= `MODE_RST; // RULE15
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `AXI_OKAY;
            s_axi_rdata   <= 32'h00000000;
        end
        else
        begin
            s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid
                             && s_axi_awvalid;
            s_axi_wready  <= !w_got_q && !s_axi_wready && !s_axi_bvalid
                             && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q  <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (aw_got_q && w_got_q && !s_axi_bvalid)
            begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (word_hit(aw_addr_q, `CTRL_OFS))
                begin
                    s_axi_bresp <= `AXI_OKAY;
                    if (w_strb_q[0])
                    begin
                        level_q  <= w_data_q[`CTRL_LEVEL_LSB +: 2];
                        arb_en_q <= w_data_q[`CTRL_ARB_EN_BIT];
                        mode_q   <= w_data_q[`CTRL_MODE_BIT];
                    end
                end
                else if (word_hit(aw_addr_q, `STAT_OFS))
                    s_axi_bresp <= `AXI_OKAY;
                else
                    s_axi_bresp <= `AXI_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;

            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                             && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= 32'h00000000;
                s_axi_rresp  <= `AXI_OKAY;
                if (word_hit(s_axi_araddr, `CTRL_OFS))
                    s_axi_rdata <= ctrl_word(level_q, arb_en_q, mode_q);
                else if (word_hit(s_axi_araddr, `STAT_OFS))
                    s_axi_rdata <= stat_word(bus_owner_indicator,
                                             bus_req_out, arb_grant_q);
                else
                    s_axi_rresp <= `AXI_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ---- hdl/arb_defs.vh ----
// Constants for the four-level bus arbiter and requester
`ifndef ARB_DEFS_VH
`define ARB_DEFS_VH
`define LEVEL_W          2
`define LEVEL_RST        2'h0
`define ARB_EN_RST       1'b1
`define MODE_ROR         1'b0
`define MODE_RWD         1'b1
`define MODE_RST         1'b0
`define CTRL_OFS         8'h00
`define STAT_OFS         8'h04
`define CTRL_LEVEL_LSB   0
`define CTRL_ARB_EN_BIT  2
`define CTRL_MODE_BIT    3
`define STAT_OWNER_BIT   0
`define STAT_REQ_BIT     1
`define STAT_ARBBUSY_BIT 2
`define STAT_ARBLVL_LSB  4
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2
`endif

// ---- hdl/grant_router.v ----
// Grant daisy-chain router: selects chain heads and pass-through paths
`timescale 1ns/1ps
module grant_router
(
    // Clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // Configuration
    input  wire       arb_en,
    input  wire [1:0] level,
    // Chain inputs
    input  wire [3:0] bus_grant_in,
    input  wire [3:0] arb_grant,
    input  wire       req_grant_out,
    // Chain outputs
    output reg  [3:0] bus_grant_out,
    output reg        req_grant_in
);
    wire [3:0] head;
    integer    i;

    assign head = arb_en ? arb_grant : bus_grant_in; // RULE8

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bus_grant_out <= 4'h0;
            req_grant_in  <= 1'b0;
        end
        else
        begin
            req_grant_in <= head[level]; // RULE16
            for (i = 0; i < 4; i = i + 1)
            begin
                if (i == level)
                    bus_grant_out[i] <= req_grant_out; // RULE16
                else
                    bus_grant_out[i] <= head[i]; // RULE6 RULE7
            end
        end
    end
endmodule

// ---- tb/arb_port_monitor.sv ----
// Port checker for the requester side, bound to the top module
`timescale 1ns/1ps
module arb_port_monitor
(
    // Clock and reset
    input wire       aclk,
    input wire       aresetn,
    // Watched ports
    input wire       xfer_req,
    input wire       xfer_go,
    input wire       bus_busy_in,
    input wire [3:0] bus_req_out,
    input wire       bus_busy_out,
    input wire       bus_owner_indicator
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_waiting;
        (|bus_req_out) && xfer_req && !bus_busy_out;
    endsequence
    sequence s_taken;
        $rose(bus_busy_out);
    endsequence
    chk_owner_mirror: assert property
        (bus_owner_indicator == bus_busy_out) else $error("owner lamp off");
    chk_one_level: assert property
        ($onehot0(bus_req_out)) else $error("request on two levels");
    chk_go_owner: assert property
        (xfer_go |-> bus_busy_out) else $error("go without ownership");
    chk_owner_quiet: assert property
        (bus_busy_out |-> bus_req_out == 4'h0) else $error("owner requests");
    chk_free_take: assert property
        (s_taken |-> $past(bus_busy_in) == 1'b0) else $error("took busy bus");
    chk_hold_req: assert property
        (s_waiting |=> bus_busy_out || $stable(bus_req_out))
        else $error("request dropped early");
    chk_req_raise: assert property
        ($rose(xfer_req) && !bus_busy_out |=> |bus_req_out)
        else $error("no request raised");
    chk_go_cause: assert property
        (xfer_go |-> $past(xfer_req)) else $error("go without need");
endmodule
bind bus_arbiter_requester arb_port_monitor i_mon
(
    .aclk(aclk), .aresetn(aresetn), .xfer_req(xfer_req),
    .xfer_go(xfer_go), .bus_busy_in(bus_busy_in),
    .bus_req_out(bus_req_out), .bus_busy_out(bus_busy_out),
    .bus_owner_indicator(bus_owner_indicator)
);

// ---- tb/vme_far_side.sv ----
// Far-side model: an external arbiter and one downstream master
`timescale 1ns/1ps
module vme_far_side
(
    // Clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // Scenario control
    input  wire       ext_on,
    input  wire       want,
    input  wire [1:0] lvl,
    // Board side of the bus
    input  wire [3:0] bus_req_out,
    input  wire       bus_busy_out,
    input  wire [3:0] bus_grant_out,
    output wire [3:0] bus_req_in,
    output reg        bus_busy_in,
    output reg  [3:0] bus_grant_in
);
    wire [3:0] mine;
    wire       busy;
    assign mine = (want && !bus_busy_in) ? (4'h1 << lvl) : 4'h0;
    assign bus_req_in = bus_req_out | mine;
    assign busy = bus_busy_out | bus_busy_in;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bus_busy_in <= 1'b0;
            bus_grant_in <= 4'h0;
        end
        else
        begin
            // Claims the bus only on a grant of its own level
            bus_busy_in <= want && (bus_busy_in
                || (bus_grant_out[lvl] && !bus_busy_out));
            // Unused chain lines float; toggling exposes any use
            if (!ext_on)
                bus_grant_in <= ~bus_grant_in;
            else if (busy || bus_req_in == 4'h0)
                bus_grant_in <= 4'h0;
            else if (bus_grant_in == 4'h0)
                bus_grant_in <= bus_req_in[3] ? 4'h8 : bus_req_in[2] ? 4'h4
                              : bus_req_in[1] ? 4'h2 : 4'h1;
        end
    end
endmodule

// ---- tb/bus_arbiter_requester_tb_top.sv ----
// Self-checking bench for the arbiter, requester and control registers
`timescale 1ns/1ps
`include "arb_defs.vh"
`define CHK(n, e, a) \
    begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module bus_arbiter_requester_tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, bvalid;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready;
    logic        arready, rvalid, xfer_go, busy_out, owner, busy_in;
    logic [1:0]  bresp, rresp, lvl = 2'h0;
    logic        xfer_req = 1'b0, xfer_done = 1'b0, ext_on = 1'b0;
    logic        want = 1'b0, clear;
    logic [3:0]  req_out, grant_out, req_in, grant_in;
    wire  [5:0]  mon = {grant_out, busy_in, busy_out};
    int          errors = 0, comparisons = 0;
    always #20 aclk = ~aclk;
    bus_arbiter_requester i_dut
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .xfer_req(xfer_req), .xfer_done(xfer_done),
        .xfer_go(xfer_go), .bus_req_in(req_in), .bus_busy_in(busy_in),
        .bus_grant_in(grant_in), .bus_req_out(req_out),
        .bus_busy_out(busy_out), .bus_grant_out(grant_out),
        .bus_clear_out(clear), .bus_owner_indicator(owner)
    );
    vme_far_side i_far
    (
        .aclk(aclk), .aresetn(aresetn), .ext_on(ext_on), .want(want),
        .lvl(lvl), .bus_req_out(req_out), .bus_busy_out(busy_out),
        .bus_grant_out(grant_out), .bus_req_in(req_in),
        .bus_busy_in(busy_in), .bus_grant_in(grant_in)
    );
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (bvalid !== 1'b1);
            `CHK("bresp", `AXI_OKAY, bresp)
            bready <= 1'b0;
            @(posedge aclk);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
            end while (rvalid !== 1'b1);
            `CHK("rdata", e, rdata)
            `CHK("rresp", er, rresp)
            rready <= 1'b0;
            @(posedge aclk);
        end
    endtask
    // Bounded wait on one monitored line
    task automatic wait_mon(input int i, input logic v);
        int n;
        begin
            n = 0;
            while (mon[i] !== v && n < 60)
            begin
                @(posedge aclk);
                n++;
            end
            `CHK("wait", v, mon[i])
        end
    endtask
    task automatic pulse_done;
        begin
            xfer_done <= 1'b1;
            @(posedge aclk);
            xfer_done <= 1'b0;
        end
    endtask
    task automatic complete_run;
        begin
            $display("checks %0d errors %0d", comparisons, errors);
            if (errors == 0 && comparisons > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`CTRL_OFS, 32'h4, `AXI_OKAY);
        wr(`STAT_OFS, 32'hFF);
        rd(`STAT_OFS, 32'h0, `AXI_OKAY);
        rd(8'h08, 32'h0, `AXI_SLVERR);
        $display("test registers done");
        want <= 1'b1;
        lvl <= 2'h2;
        xfer_req <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK("req0", 4'h1, req_out)
        wait_mon(1, 1'b1);
        `CHK("lost", 1'b0, owner)
        @(posedge aclk);
        `CHK("clear", 1'b1, clear)
        want <= 1'b0;
        wait_mon(0, 1'b1);
        @(posedge aclk);
        `CHK("go", 1'b1, xfer_go)
        `CHK("kept", 4'h0, grant_out)
        want <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK("hold", 1'b1, owner)
        xfer_req <= 1'b0;
        wait_mon(4, 1'b1);
        `CHK("freed", 1'b0, owner)
        want <= 1'b0;
        wait_mon(1, 1'b0);
        $display("test release_on_request done");
        wr(`CTRL_OFS, 32'hF);
        xfer_req <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK("req3", 4'h8, req_out)
        wait_mon(0, 1'b1);
        rd(`STAT_OFS, 32'h1, `AXI_OKAY);
        pulse_done;
        wait_mon(0, 1'b0);
        wait_mon(0, 1'b1);
        xfer_req <= 1'b0;
        pulse_done;
        wait_mon(0, 1'b0);
        $display("test release_when_done done");
        wr(`CTRL_OFS, 32'h1);
        ext_on <= 1'b1;
        // Floating lines take three flops to flush through the own level
        repeat (5) @(posedge aclk);
        `CHK("heads", 4'h0, grant_out)
        for (int k = 0; k < 4; k++)
        begin
            lvl <= k[1:0];
            want <= 1'b1;
            wait_mon(2 + k, 1'b1);
            wait_mon(1, 1'b1);
            want <= 1'b0;
            wait_mon(1, 1'b0);
        end
        xfer_req <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK("req1", 4'h2, req_out)
        wait_mon(0, 1'b1);
        $display("test external_arbiter done");
        complete_run();
    end
    initial
    begin
        #400000;
        errors++;
        complete_run();
    end
endmodule
